// [design/albx_pkg.sv]
// Shared constants and carriers for the add/logic/branch execution slice
package albx_pkg;
  // ----------------------------------------------------------------
  // Instruction field positions (bit 0 of word is the rightmost bit)
  // ----------------------------------------------------------------
  localparam int PRI_LSB = 26;
  localparam int RT_LSB = 21;
  localparam int RA_LSB = 16;
  localparam int RB_LSB = 11;
  localparam int OE_BIT = 10;
  localparam int XO9_LSB = 1;
  localparam int XO10_LSB = 1;
  localparam int RC_BIT = 0;
  localparam int AA_BIT = 1;
  localparam int LK_BIT = 0;
  localparam int LI_LSB = 2;
  localparam int BD_LSB = 2;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_EXT = 6'h1F;
  localparam logic [5:0] OP_ANDI = 6'h1C;
  localparam logic [5:0] OP_ANDIS = 6'h1D;
  localparam logic [5:0] OP_ADDIC = 6'h0C;
  localparam logic [5:0] OP_ADDIC_REC = 6'h0D;
  localparam logic [5:0] OP_B = 6'h12;
  localparam logic [5:0] OP_BC = 6'h10;
  localparam logic [8:0] XO_ADDME = 9'h0EA;
  localparam logic [8:0] XO_ADDZE = 9'h0CA;
  localparam logic [9:0] XO_AND = 10'h01C;
  localparam logic [9:0] XO_ANDC = 10'h03C;
  // ----------------------------------------------------------------
  // Branch option bits, numbered from the left of the 5-bit field
  // ----------------------------------------------------------------
  localparam int BO0 = 4;
  localparam int BO1 = 3;
  localparam int BO2 = 2;
  localparam int BO3 = 1;
  localparam int BO4 = 0;
  // ----------------------------------------------------------------
  // Condition field zero and exception register bits
  // ----------------------------------------------------------------
  localparam int CR_LT = 31;
  localparam int CR_GT = 30;
  localparam int CR_EQ = 29;
  localparam int CR_SO = 28;
  localparam int XER_SO = 31;
  localparam int XER_OV = 30;
  localparam int XER_CA = 29;
  localparam logic [31:0] MINUS_ONE = 32'hFFFFFFFF;
  localparam logic [31:0] INSN_STEP = 32'h00000004;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  // ----------------------------------------------------------------
  // APB register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CR = 12'h000;
  localparam logic [11:0] REG_XER = 12'h004;
  localparam logic [11:0] REG_LR = 12'h008;
  localparam logic [11:0] REG_CTR = 12'h00C;
  localparam logic [11:0] REG_NIA = 12'h010;
  localparam logic [11:0] REG_STAT = 12'h014;
  localparam logic [11:0] REG_GPR_BASE = 12'h080;
  localparam logic [11:0] REG_GPR_LAST = 12'h0FC;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [31:0] word;
    logic [31:0] addr;
  } albx_insn_t;

  typedef struct packed {
    logic retire;
    logic [31:0] next_insn_addr;
    logic predict_taken;
    logic invalid_form;
  } albx_result_t;
endpackage

// [design/albx_exec.sv]
// Execution slice: extended adds, AND forms, branches, with APB access
`timescale 1ns/1ns
module albx_exec (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [albx_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pipeline side
  input wire albx_pkg::albx_insn_t insn,
  output albx_pkg::albx_result_t result
);
  import albx_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] gpr_q [32];
  logic [31:0] gpr_d [32];
  logic [31:0] cr_q, cr_d, xer_q, xer_d, lr_q, lr_d, ctr_q, ctr_d;
  logic [31:0] nia_q, nia_d, prdata_q, prdata_d;
  logic retire_q, retire_d, hint_q, hint_d, inval_q, inval_d;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [31:0] w;
  logic [5:0] pri;
  logic [4:0] rt, ra, rb;
  logic [8:0] xo9;
  logic [9:0] xo10;
  logic oe, rc, aa, lk;
  logic is_addme, is_addze, is_and, is_andc, is_andi, is_andis, is_addic, is_addicr;
  logic is_b, is_bc, is_ext_add, bad_form, known;

  assign w = insn.word;
  assign pri = w[PRI_LSB +: 6];
  assign rt = w[RT_LSB +: 5];
  assign ra = w[RA_LSB +: 5];
  assign rb = w[RB_LSB +: 5];
  assign xo9 = w[XO9_LSB +: 9];
  assign xo10 = w[XO10_LSB +: 10];
  assign oe = w[OE_BIT];
  assign rc = w[RC_BIT];
  assign aa = w[AA_BIT];
  assign lk = w[LK_BIT];
  assign is_addme = pri == OP_EXT && xo9 == XO_ADDME;
  assign is_addze = pri == OP_EXT && xo9 == XO_ADDZE;
  assign is_and = pri == OP_EXT && xo10 == XO_AND;
  assign is_andc = pri == OP_EXT && xo10 == XO_ANDC;
  assign is_andi = pri == OP_ANDI;
  assign is_andis = pri == OP_ANDIS;
  assign is_addic = pri == OP_ADDIC;
  assign is_addicr = pri == OP_ADDIC_REC;
  assign is_b = pri == OP_B;
  assign is_bc = pri == OP_BC;
  assign is_ext_add = is_addme || is_addze;
  // Reserved source_b slot must be zero in the extended adds
  assign bad_form = is_ext_add && rb != 5'h00;
  assign known = is_ext_add || is_and || is_andc || is_andi || is_andis
                 || is_addic || is_addicr || is_b || is_bc;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic [31:0] opa, opb, addend, logic_res, res;
  logic [32:0] sum;
  logic cin, ovf, so_new;
  logic [31:0] b_disp, bc_disp, b_target, bc_target, seq_addr, ctr_dec;
  logic [4:0] bo;
  logic ctr_ok, cond_ok, taken;

  assign opa = gpr_q[ra];
  assign opb = gpr_q[rb];
  // Extended adds feed the carry; add-immediate does not
  assign cin = is_ext_add ? xer_q[XER_CA] : 1'b0;
  always_comb begin
    if (is_addme) begin
      addend = MINUS_ONE;
    end else if (is_addic || is_addicr) begin
      addend = {{16{w[15]}}, w[15:0]};
    end else begin
      addend = RESET_WORD;
    end
  end
  // Carry taken from the 33rd bit, not from signed overflow
  assign sum = {1'b0, opa} + {1'b0, addend} + {32'h00000000, cin};
  assign ovf = (opa[31] == addend[31]) && (sum[31] != opa[31]);

  always_comb begin
    if (is_andc) begin
      logic_res = gpr_q[rt] & ~opb;
    end else if (is_andi) begin
      logic_res = gpr_q[rt] & {16'h0000, w[15:0]};
    end else if (is_andis) begin
      logic_res = gpr_q[rt] & {w[15:0], 16'h0000};
    end else begin
      logic_res = gpr_q[rt] & opb;
    end
  end
  assign res = (is_ext_add || is_addic || is_addicr) ? sum[31:0] : logic_res;

  assign b_disp = {{6{w[25]}}, w[LI_LSB +: 24], 2'b00};
  assign bc_disp = {{16{w[15]}}, w[BD_LSB +: 14], 2'b00};
  assign seq_addr = insn.addr + INSN_STEP;
  assign b_target = (aa ? RESET_WORD : insn.addr) + b_disp;
  assign bc_target = (aa ? RESET_WORD : insn.addr) + bc_disp;
  assign bo = w[RT_LSB +: 5];
  assign ctr_dec = ctr_q - 32'h00000001;
  // Counter tested after its decrement
  assign ctr_ok = bo[BO2] || ((ctr_dec == RESET_WORD) == bo[BO3]);
  assign cond_ok = bo[BO0] || (cr_q[31 - ra] == bo[BO1]);
  assign taken = ctr_ok && cond_ok;

  // ----------------------------------------------------------------
  // Next state: APB writes first, retiring instruction overlays them
  // ----------------------------------------------------------------
  logic apb_wr, apb_setup, exec, rec, upd_ca;
  logic [4:0] gidx;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign gidx = paddr[6:2];
  assign exec = insn.valid && known && !bad_form;
  assign rec = ((is_ext_add || is_and || is_andc) && rc) || is_andi || is_andis
               || is_addicr;
  assign upd_ca = is_ext_add || is_addic || is_addicr;

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      gpr_d[i] = gpr_q[i];
    end
    cr_d = cr_q;
    xer_d = xer_q;
    lr_d = lr_q;
    ctr_d = ctr_q;
    nia_d = nia_q;
    hint_d = hint_q;
    so_new = xer_q[XER_SO];
    retire_d = insn.valid;
    inval_d = insn.valid && (!known || bad_form);
    if (apb_wr) begin
      unique case (paddr)
        REG_CR: cr_d = pwdata;
        REG_XER: xer_d = pwdata;
        REG_LR: lr_d = pwdata;
        REG_CTR: ctr_d = pwdata;
        default: begin
          if (paddr >= REG_GPR_BASE && paddr <= REG_GPR_LAST) begin
            gpr_d[gidx] = pwdata;
          end
        end
      endcase
    end
    if (insn.valid) begin
      nia_d = seq_addr;
      hint_d = 1'b0;
    end
    if (exec) begin
      if (is_b) begin
        nia_d = b_target;
        hint_d = 1'b1;
      end else if (is_bc) begin
        if (!bo[BO2]) begin
          ctr_d = ctr_dec;
        end
        nia_d = taken ? bc_target : seq_addr;
        // Always-branch forms predict taken; otherwise backward unless flipped
        hint_d = (bo[BO0] && bo[BO2]) || (w[15] ^ bo[BO4]);
      end else if (is_ext_add || is_addic || is_addicr) begin
        gpr_d[rt] = res;
      end else begin
        gpr_d[ra] = res;
      end
      if (is_b || is_bc) begin
        if (lk) begin
          lr_d = seq_addr;
        end
      end
      if (upd_ca) begin
        xer_d[XER_CA] = sum[32];
      end
      if (is_ext_add && oe) begin
        xer_d[XER_OV] = ovf;
        xer_d[XER_SO] = xer_q[XER_SO] | ovf;
        so_new = xer_q[XER_SO] | ovf;
      end
      if (rec) begin
        cr_d[CR_LT] = res[31];
        cr_d[CR_GT] = !res[31] && res != RESET_WORD;
        cr_d[CR_EQ] = res == RESET_WORD;
        cr_d[CR_SO] = so_new;
      end
    end
  end

  // APB read data latched in the setup phase, so zero wait states
  always_comb begin
    prdata_d = prdata_q;
    if (apb_setup) begin
      unique case (paddr)
        REG_CR: prdata_d = cr_q;
        REG_XER: prdata_d = xer_q;
        REG_LR: prdata_d = lr_q;
        REG_CTR: prdata_d = ctr_q;
        REG_NIA: prdata_d = nia_q;
        REG_STAT: prdata_d = {29'h00000000, inval_q, hint_q, retire_q};
        default: begin
          if (paddr >= REG_GPR_BASE && paddr <= REG_GPR_LAST) begin
            prdata_d = gpr_q[gidx];
          end else begin
            prdata_d = RESET_WORD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= RESET_WORD;
      end
      cr_q <= RESET_WORD;
      xer_q <= RESET_WORD;
      lr_q <= RESET_WORD;
      ctr_q <= RESET_WORD;
      nia_q <= RESET_WORD;
      prdata_q <= RESET_WORD;
      retire_q <= 1'b0;
      hint_q <= 1'b0;
      inval_q <= 1'b0;
    end else begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= gpr_d[i];
      end
      cr_q <= cr_d;
      xer_q <= xer_d;
      lr_q <= lr_d;
      ctr_q <= ctr_d;
      nia_q <= nia_d;
      prdata_q <= prdata_d;
      retire_q <= retire_d;
      hint_q <= hint_d;
      inval_q <= inval_d;
    end
  end

  logic mapped;
  assign mapped = paddr == REG_CR || paddr == REG_XER || paddr == REG_LR
                  || paddr == REG_CTR || paddr == REG_NIA || paddr == REG_STAT
                  || (paddr >= REG_GPR_BASE && paddr <= REG_GPR_LAST);
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign result.retire = retire_q;
  assign result.next_insn_addr = nia_q;
  assign result.predict_taken = hint_q;
  assign result.invalid_form = inval_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_addme_value: assert property (@(posedge pclk) disable iff (!presetn)
    exec && is_addme |=> gpr_q[$past(rt)] == $past(opa + {31'h0, xer_q[XER_CA]} + MINUS_ONE))
    else $error("addme result wrong");
  a_carry_magnitude: assert property (@(posedge pclk) disable iff (!presetn)
    exec && is_ext_add |=> xer_q[XER_CA] == $past(sum[32]))
    else $error("carry not from unsigned sum");
  a_oe_hold: assert property (@(posedge pclk) disable iff (!presetn)
    exec && is_ext_add && !oe && !apb_wr |=> xer_q[XER_OV] == $past(xer_q[XER_OV]))
    else $error("overflow changed with enable low");
  a_andis_mask: assert property (@(posedge pclk) disable iff (!presetn)
    exec && is_andis |=> gpr_q[$past(ra)] == ($past(gpr_q[rt]) & {$past(w[15:0]), 16'h0}))
    else $error("high literal AND wrong");
  a_andi_record: assert property (@(posedge pclk) disable iff (!presetn)
    exec && is_andi |=> cr_q[CR_EQ] == (gpr_q[$past(ra)] == RESET_WORD))
    else $error("literal AND did not record");
  a_link_load: assert property (@(posedge pclk) disable iff (!presetn)
    exec && (is_b || is_bc) && lk |=> lr_q == $past(insn.addr) + INSN_STEP)
    else $error("link register not loaded");
  a_ctr_decr: assert property (@(posedge pclk) disable iff (!presetn)
    exec && is_bc && !bo[BO2] && !apb_wr |=> ctr_q == $past(ctr_q) - 32'h1)
    else $error("counter not decremented");
  a_bc_fallthru: assert property (@(posedge pclk) disable iff (!presetn)
    exec && is_bc && !taken |=> result.retire && nia_q == $past(insn.addr) + INSN_STEP)
    else $error("untaken branch bad next address");
  a_b_target: assert property (@(posedge pclk) disable iff (!presetn)
    exec && is_b && aa |=> nia_q == $past(b_disp))
    else $error("absolute branch target wrong");
  a_bad_form: assert property (@(posedge pclk) disable iff (!presetn)
    insn.valid && bad_form && !apb_wr |=> result.invalid_form && gpr_q[$past(rt)] ==
    $past(gpr_q[rt]))
    else $error("invalid form changed state");
  c_bc_taken: cover property (@(posedge pclk) disable iff (!presetn) exec && is_bc && taken);
  c_addme_carry: cover property (@(posedge pclk) disable iff (!presetn)
    exec && is_addme && sum[32]);
  c_andis_rec: cover property (@(posedge pclk) disable iff (!presetn) exec && is_andis);
endmodule

// [verification/albx_pipe_model.sv]
// Pipeline stand-in that issues queued instructions to the execution slice
`timescale 1ns/1ns
module albx_pipe_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Issue side
  output albx_pkg::albx_insn_t insn
);
  import albx_pkg::*;
  logic [31:0] word_q[$];
  logic [31:0] addr_q[$];

  task automatic push(input logic [31:0] w, input logic [31:0] a);
    word_q.push_back(w);
    addr_q.push_back(a);
  endtask

  initial insn = '0;
  // One instruction per cycle, back to back while the queue holds work
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn <= '0;
    end else if (word_q.size() > 0) begin
      insn <= {1'b1, word_q.pop_front(), addr_q.pop_front()};
    end else begin
      // Idle lines toggle so a stale word never looks like a fresh one
      insn.valid <= 1'b0;
      insn.word <= ~insn.word;
      insn.addr <= ~insn.addr;
    end
  end
endmodule

// [verification/test_add_logic_branch_exec.sv]
// Self-checking bench for the add/logic/branch execution slice
`timescale 1ns/1ns
module test_add_logic_branch_exec;
  import albx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv, m_cr, m_xer, m_lr, m_ctr, m_nia, r;
  logic [31:0] m_gpr[32];
  logic [34:0] exp_q[$];
  albx_insn_t insn;
  albx_result_t result;
  int errors, num_checks, cycles, seed;

  albx_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .insn(insn), .result(result));
  albx_pipe_model pipe (.pclk(pclk), .presetn(presetn), .insn(insn));

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic state_chk();
    for (int i = 0; i < 32; i++) begin
      apb(1'b0, REG_GPR_BASE + 12'(4 * i), 32'h0); chk(rdv, m_gpr[i]);
    end
    apb(1'b0, REG_CR, 32'h0); chk(rdv, m_cr);
    apb(1'b0, REG_XER, 32'h0); chk(rdv, m_xer);
    apb(1'b0, REG_LR, 32'h0); chk(rdv, m_lr);
    apb(1'b0, REG_CTR, 32'h0); chk(rdv, m_ctr);
    apb(1'b0, REG_NIA, 32'h0); chk(rdv, m_nia);
  endtask

  // ----------------------------------------------------------------
  // Reference model, run in issue order
  // ----------------------------------------------------------------
  task automatic model(input logic [31:0] w, input logic [31:0] a);
    logic [4:0] f1, f2, f3;
    logic [32:0] s;
    logic [31:0] res, disp, addend, av;
    logic rec, br, hint, inv, ov, take;
    f1 = w[25:21]; f2 = w[20:16]; f3 = w[15:11]; av = m_gpr[w[20:16]];
    rec = 1'b0; br = 1'b0; hint = 1'b0; inv = 1'b0; m_nia = a + 32'h4;
    if (w[31:26] == OP_EXT && (w[9:1] == XO_ADDME || w[9:1] == XO_ADDZE)) begin
      addend = (w[9:1] == XO_ADDME) ? 32'hFFFFFFFF : 32'h0;
      if (f3 != 5'h0) inv = 1'b1;
      else begin
        s = {1'b0, av} + {1'b0, addend} + m_xer[XER_CA];
        res = s[31:0]; m_gpr[f1] = res; m_xer[XER_CA] = s[32];
        if (w[10]) begin
          ov = (av[31] == addend[31]) && (res[31] != av[31]);
          m_xer[XER_OV] = ov; m_xer[XER_SO] = m_xer[XER_SO] | ov;
        end
        rec = w[0];
      end
    end else if (w[31:26] == OP_EXT && (w[10:1] == XO_AND || w[10:1] == XO_ANDC)) begin
      res = m_gpr[f1] & ((w[10:1] == XO_AND) ? m_gpr[f3] : ~m_gpr[f3]);
      m_gpr[f2] = res; rec = w[0];
    end else if (w[31:26] == OP_ANDI || w[31:26] == OP_ANDIS) begin
      res = m_gpr[f1] & ((w[31:26] == OP_ANDI) ? {16'h0, w[15:0]} : {w[15:0], 16'h0});
      m_gpr[f2] = res; rec = 1'b1;
    end else if (w[31:26] == OP_ADDIC_REC || w[31:26] == OP_ADDIC) begin
      s = {1'b0, av} + {1'b0, {{16{w[15]}}, w[15:0]}};
      res = s[31:0]; m_gpr[f1] = res; m_xer[XER_CA] = s[32];
      rec = (w[31:26] == OP_ADDIC_REC);
    end else if (w[31:26] == OP_B) begin
      br = 1'b1; hint = 1'b1; disp = {{6{w[25]}}, w[25:2], 2'b00};
      m_nia = (w[1] ? 32'h0 : a) + disp;
      if (w[0]) m_lr = a + 32'h4;
    end else if (w[31:26] == OP_BC) begin
      br = 1'b1; disp = {{16{w[15]}}, w[15:2], 2'b00};
      if (!f1[2]) m_ctr = m_ctr - 32'h1;
      take = (f1[2] || ((m_ctr == 32'h0) == f1[1])) && (f1[4] || (m_cr[31 - f2] == f1[3]));
      hint = (f1[4] && f1[2]) ? 1'b1 : (w[15] ^ f1[0]);
      if (take) m_nia = (w[1] ? 32'h0 : a) + disp;
      if (w[0]) m_lr = a + 32'h4;
    end else inv = 1'b1;
    if (rec) m_cr[31:28] = {$signed(res) < 0, $signed(res) > 0, res == 32'h0, m_xer[XER_SO]};
    exp_q.push_back({br, hint, inv, m_nia});
    pipe.push(w, a);
  endtask

  task automatic rand_insn(input int k, input logic [31:0] a);
    logic [31:0] w;
    r = $random(seed);
    case (k)
      0, 1: w = {OP_EXT, r[25:16], (r[3:1] == 3'h0) ? r[15:11] : 5'h0, r[10],
        (k == 0) ? XO_ADDME : XO_ADDZE, r[0]};
      2, 3: w = {OP_EXT, r[25:11], (k == 2) ? XO_AND : XO_ANDC, r[0]};
      4: w = {OP_ANDI, r[25:0]};
      5: w = {OP_ANDIS, r[25:0]};
      6: w = {OP_ADDIC_REC, r[25:0]};
      7: w = {OP_B, r[25:0]};
      8: w = {OP_BC, r[25:0]};
      9: w = r[26] ? {OP_ADDIC, r[25:0]} : {6'h00, r[25:0]};
      default: w = {6'h00, r[25:0]};
    endcase
    model(w, a);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 100) begin @(posedge pclk); n++; end
    repeat (2) @(posedge pclk);
    chk(32'(exp_q.size()), 32'h0);
  endtask

  // Every retire is compared against the next modelled instruction
  always @(posedge pclk) begin
    logic [34:0] e;
    if (presetn === 1'b1 && result.retire === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("MISMATCH t=%0t unexpected retire", $time);
      end else begin
        e = exp_q.pop_front();
        chk(result.next_insn_addr, e[31:0]);
        chk({31'h0, result.invalid_form}, {31'h0, e[32]});
        if (e[34]) chk({31'h0, result.predict_taken}, {31'h0, e[33]});
      end
    end
  end

  initial begin
    seed = 32'h75B7BC59;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = 32'h0;
    m_cr = 32'h0; m_xer = 32'h0; m_lr = 32'h0; m_ctr = 32'h0; m_nia = 32'h0;
    foreach (m_gpr[i]) m_gpr[i] = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    state_chk();
    apb(1'b1, 12'h040, 32'hFFFFFFFF); chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h040, 32'h0); chk(rdv, 32'h0);
    apb(1'b1, REG_NIA, 32'h12345678); chk({31'h0, err}, 32'h0);
    apb(1'b0, REG_NIA, 32'h0); chk(rdv, 32'h0);
    chk({31'h0, pready}, 32'h1);
    for (int i = 0; i < 32; i++) begin
      m_gpr[i] = (i == 1) ? 32'hFFFFFFFF : (i == 4) ? 32'h7FFFFFFF : $random(seed);
      apb(1'b1, REG_GPR_BASE + 12'(4 * i), m_gpr[i]);
    end
    m_xer = 32'h20000000;
    apb(1'b1, REG_XER, m_xer);
    // Carry chain and overflow corners, issued back to back
    model({OP_EXT, 5'd2, 5'd1, 5'd0, 1'b1, XO_ADDZE, 1'b1}, 32'h1000);
    model({OP_EXT, 5'd3, 5'd2, 5'd0, 1'b1, XO_ADDME, 1'b1}, 32'h1004);
    model({OP_EXT, 5'd5, 5'd4, 5'd0, 1'b1, XO_ADDZE, 1'b1}, 32'h1008);
    model({OP_B, 24'hFFFFFF, 1'b0, 1'b1}, 32'h100C);
    drain();
    state_chk();
    for (int b = 0; b < 110; b++) begin
      m_ctr = $random(seed) & 32'h3; m_cr = $random(seed); m_xer = $random(seed) & 32'hE0000000;
      apb(1'b1, REG_CTR, m_ctr);
      apb(1'b1, REG_CR, m_cr);
      apb(1'b1, REG_XER, m_xer);
      for (int j = 0; j <= b % 3; j++) begin
        r = $random(seed);
        rand_insn((b * 3 + j) % 10, {r[31:2], 2'b00});
      end
      drain();
      if (b % 4 == 0) state_chk();
    end
    state_chk();
    end_sim();
  end
endmodule
